//--- verilog/mtd_pkg.sv
// Constants, field layout and register map of the message trap and display block
// Assumes a 125 MHz system clock and a classic Wishbone master for the registers
// Notes on behaviour
// (R1) Parity bit toggles on each one bit
// (R2) Load strobe samples parity, sets error flag
// (R3) Parity criterion stores parity-errored messages
// (R4) Parity indicator lights on every parity error
// (R5) Address criterion compares three address fields
// (R6) Ignored field always counts as matching
// (R7) Full match loads message into storage
// (R8) Each store gives stretched update indicator
// (R9) Octal display of data or address
// (R10) Address display blanks third, fifth digit
// (R11) Analogue modes pick upper or lower half
// (R12) Multiply by five as shift-two plus value
// (R13) Negative values shown as sign and magnitude
// (R14) Combinational binary to five BCD digits
// (R15) Three-bit scan counter near 5 kHz
// (R16) One-of-eight digit enable from scan counter
// (R17) Digit code to seven shared segments
// (R18) Analogue: point on fifth, blank 0,1, and 7 unless negative
// (R19) Analogue: leading zero off, minus sign
// (R20) Lamps show stored bits 23 down to 0
// (R21) Store loads both converter words
// (R22) Converter word is offset binary, MSB inverted
// (R23) Ten-bit converter gets upper ten bits
// (R24) Loader strobes when message fully loaded
// (R25) Repeat stores all, single once per press
// (R26) Storage holds; decision once per strobe
// (R27) Single arm: synced, edge-detected, cleared on store
package mtd_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int SCAN_HZ = 5000;
  localparam int SCAN_CYC = CLK_HZ / SCAN_HZ;
  localparam int LED_MS = 50;
  localparam int LED_CYC = CLK_HZ / 1000 * LED_MS;

  // ****************************************
  // Message layout
  // ****************************************
  localparam int INFO_W = 24;
  localparam int ADDR_W = 16;
  localparam int MSG_W = INFO_W + ADDR_W;
  localparam int HALF_W = 12;
  localparam int ST_LSB = 10;
  localparam int ST_W = 6;
  localparam int DSF_LSB = 6;
  localparam int DSF_W = 4;
  localparam int CH_LSB = 0;
  localparam int CH_W = 6;
  localparam logic PAR_GOOD = 1'b0;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MATCH = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_INFO = 8'h0c;
  localparam int CTRL_W = 7;
  localparam int CTRL_TRAP_ADDR = 0;
  localparam int CTRL_REP = 1;
  localparam int CTRL_IGN_ST = 2;
  localparam int CTRL_IGN_DSET = 3;
  localparam int CTRL_IGN_CH = 4;
  localparam int CTRL_DISP_LSB = 5;
  localparam logic [6:0] CTRL_RST = 7'h02;
  localparam int STAT_PERR = 0;
  localparam int STAT_ARMED = 1;
  localparam int STAT_UPD = 2;
  localparam int STAT_ADDR_LSB = 16;

  // ****************************************
  // Display
  // ****************************************
  typedef enum logic [1:0] {
    DISP_OCT_DATA = 2'h0,
    DISP_OCT_ADDR = 2'h1,
    DISP_MUX = 2'h2,
    DISP_MUX1 = 2'h3
  } mtd_disp_t;
  localparam logic [3:0] CODE_MINUS = 4'ha;
  localparam logic [3:0] CODE_BLANK = 4'hf;

endpackage

//--- verilog/mtd_top.sv
// Message trap: storage decision, display scan, lamp array and converter words
// Assumes the message input register and its loader are outside, synchronous to clk_i
`timescale 1ns/10ps
module mtd_top
  import mtd_pkg::*;
#(
  parameter int SCAN_DIV = SCAN_CYC,
  parameter int LED_CYCLES = LED_CYC,
  parameter int DAC_W = 12
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic msg_bit_i,
  input wire logic msg_shift_i,
  input wire logic load_done_i,
  input wire logic [MSG_W-1:0] msg_data_i,
  input wire logic single_btn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [6:0] seg_o,
  output logic dp_o,
  output logic [7:0] digit_en_o,
  output logic [INFO_W-1:0] lamp_o,
  output logic [DAC_W-1:0] dac_a_o,
  output logic [DAC_W-1:0] dac_b_o,
  output logic parity_led_o,
  output logic update_led_o
);

  localparam int SCW = $clog2(SCAN_DIV);
  localparam int LCW = $clog2(LED_CYCLES + 1);

  // ****************************************
  // Parameter checks
  // ****************************************
  if ((DAC_W != 12 && DAC_W != 10) || SCAN_DIV < 2 || LED_CYCLES < 3)
  begin : g_par_chk
    $error("DAC_W must be 12 or 10, SCAN_DIV at least 2, LED_CYCLES at least 3");
  end

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl_r;
    logic [ADDR_W-1:0] match_r;
    logic par_r;
    logic perr_r;
    logic [ADDR_W-1:0] addr_r;
    logic [INFO_W-1:0] info_r;
    logic armed_r;
    logic [1:0] btn_sync_r;
    logic btn_prev_r;
    logic [LCW:0] upd_r;
    logic [LCW:0] per_r;
    logic [SCW-1:0] div_r;
    logic [2:0] scan_r;
    logic [6:0] seg_r;
    logic dp_r;
    logic [7:0] en_r;
    logic [DAC_W-1:0] dac_a_r;
    logic [DAC_W-1:0] dac_b_r;
    logic ack_r;
    logic [31:0] rdat_r;
  } mtd_state_t;

  mtd_state_t st_r;
  mtd_state_t st_nxt;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [19:0] bcd5(input logic [15:0] b);
    logic [35:0] w;
    w = {20'h0, b};
    for (int i = 0; i < 16; i++)
    begin
      for (int j = 0; j < 5; j++)
      begin
        if (w[16+4*j+:4] > 4'd4)
          w[16+4*j+:4] = 4'(w[16+4*j+:4] + 4'd3);
      end
      w = {w[34:0], 1'b0};
    end
    return w[35:16];
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] c);
    case (c)
      4'h0: return 7'h3f;
      4'h1: return 7'h06;
      4'h2: return 7'h5b;
      4'h3: return 7'h4f;
      4'h4: return 7'h66;
      4'h5: return 7'h6d;
      4'h6: return 7'h7d;
      4'h7: return 7'h07;
      4'h8: return 7'h7f;
      4'h9: return 7'h6f;
      CODE_MINUS: return 7'h40;
      default: return 7'h00;
    endcase
  endfunction

  function automatic logic [LCW:0] stretch(input logic ev, input logic [LCW:0] cur);
    if (ev)
      return {1'b1, LCW'(LED_CYCLES - 1)};
    else if (cur[LCW-1:0] != '0)
      return {1'b1, LCW'(cur[LCW-1:0] - 1'b1)};
    else
      return '0;
  endfunction

  function automatic logic [DAC_W-1:0] to_dac(input logic [HALF_W-1:0] h);
    logic [HALF_W-1:0] ob;
    ob = {~h[HALF_W-1], h[HALF_W-2:0]};
    return ob[HALF_W-1-:DAC_W];
  endfunction

  // ****************************************
  // Storage decision
  // ****************************************
  mtd_disp_t mode;
  logic [ADDR_W-1:0] msg_addr;
  logic msg_err;
  logic addr_hit;
  logic trap;
  logic store;
  logic btn_edge;

  assign mode = mtd_disp_t'(st_r.ctrl_r[CTRL_DISP_LSB+:2]);
  assign msg_addr = msg_data_i[MSG_W-1:INFO_W];
  // (R2) parity error at strobe
  assign msg_err = st_r.par_r != PAR_GOOD;
  // (R5) (R6) field compare with ignore
  assign addr_hit = (st_r.ctrl_r[CTRL_IGN_ST] ||
                     msg_addr[ST_LSB+:ST_W] == st_r.match_r[ST_LSB+:ST_W]) &&
                    (st_r.ctrl_r[CTRL_IGN_DSET] ||
                     msg_addr[DSF_LSB+:DSF_W] == st_r.match_r[DSF_LSB+:DSF_W]) &&
                    (st_r.ctrl_r[CTRL_IGN_CH] ||
                     msg_addr[CH_LSB+:CH_W] == st_r.match_r[CH_LSB+:CH_W]);
  // (R3) (R7) choice of criterion
  assign trap = st_r.ctrl_r[CTRL_TRAP_ADDR] ? addr_hit : msg_err;
  // (R25) (R26) once per strobe, repeat or armed
  assign store = load_done_i && trap && (st_r.ctrl_r[CTRL_REP] || st_r.armed_r);
  assign btn_edge = st_r.btn_sync_r[1] && !st_r.btn_prev_r;

  // ****************************************
  // Analogue value
  // ****************************************
  logic [HALF_W-1:0] half;
  logic neg;
  logic [HALF_W-1:0] mag;
  logic [15:0] mv;
  logic [19:0] bcd;

  // (R11) half select
  assign half = (mode == DISP_MUX) ? st_r.info_r[INFO_W-1:HALF_W] : st_r.info_r[HALF_W-1:0];
  assign neg = half[HALF_W-1];
  // (R13) complement negative values
  assign mag = neg ? HALF_W'(~half + 1'b1) : half;
  // (R12) times four plus value
  assign mv = 16'({2'b00, mag, 2'b00} + {4'h0, mag});
  // (R14) binary to BCD
  assign bcd = bcd5(mv);

  // ****************************************
  // Next state
  // ****************************************
  logic [3:0] code;
  logic dp;
  logic [2:0] pos;
  logic [2:0] oidx;
  logic [17:0] addr18;
  logic [31:0] lane;
  logic wb_req;

  always_comb
  begin
    st_nxt = st_r;
    code = CODE_BLANK;
    dp = 1'b0;
    oidx = 3'h0;
    addr18 = {2'b00, st_r.addr_r};
    lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wb_req = wb_cyc_i && wb_stb_i && !st_r.ack_r;

    // Bus slave: ack one cycle after request
    st_nxt.ack_r = wb_req;
    st_nxt.rdat_r = 32'h0;
    if (wb_req)
    begin
      case (wb_adr_i)
        REG_CTRL:
        begin
          st_nxt.rdat_r = {25'h0, st_r.ctrl_r};
          if (wb_we_i)
            st_nxt.ctrl_r = CTRL_W'((st_r.ctrl_r & ~lane[CTRL_W-1:0]) | (wb_dat_i[CTRL_W-1:0] & lane[CTRL_W-1:0]));
        end
        REG_MATCH:
        begin
          st_nxt.rdat_r = {16'h0, st_r.match_r};
          if (wb_we_i)
            st_nxt.match_r = (st_r.match_r & ~lane[15:0]) | (wb_dat_i[15:0] & lane[15:0]);
        end
        REG_STAT:
        begin
          st_nxt.rdat_r = {st_r.addr_r, 13'h0, st_r.upd_r[LCW], st_r.armed_r, st_r.perr_r};
          if (wb_we_i && wb_sel_i[0] && wb_dat_i[STAT_PERR])
            st_nxt.perr_r = 1'b0;
        end
        REG_INFO:
          st_nxt.rdat_r = {8'h0, st_r.info_r};
        default:
          st_nxt.rdat_r = 32'h0;
      endcase
    end

    // (R1) parity toggle per one bit
    if (load_done_i)
      st_nxt.par_r = 1'b0;
    else if (msg_shift_i && msg_bit_i)
      st_nxt.par_r = !st_r.par_r;
    // (R2) error flag, set wins over clear
    if (load_done_i && msg_err)
      st_nxt.perr_r = 1'b1;
    // (R4) parity indicator per error
    st_nxt.per_r = stretch(load_done_i && msg_err, st_r.per_r);
    // (R8) stretched update indicator
    st_nxt.upd_r = stretch(store, st_r.upd_r);

    // (R27) synced, edge-detected arm
    st_nxt.btn_sync_r = {st_r.btn_sync_r[0], single_btn_i};
    st_nxt.btn_prev_r = st_r.btn_sync_r[1];
    if (store)
      st_nxt.armed_r = 1'b0;
    if (btn_edge)
      st_nxt.armed_r = 1'b1;

    // (R3) (R7) (R21) parallel load on store
    if (store)
    begin
      st_nxt.addr_r = msg_addr;
      st_nxt.info_r = msg_data_i[INFO_W-1:0];
      // (R22) (R23) offset binary words
      st_nxt.dac_a_r = to_dac(msg_data_i[INFO_W-1:HALF_W]);
      st_nxt.dac_b_r = to_dac(msg_data_i[HALF_W-1:0]);
    end

    // (R15) scan divider and counter
    if (st_r.div_r == SCW'(SCAN_DIV - 1))
    begin
      st_nxt.div_r = '0;
      st_nxt.scan_r = 3'(st_r.scan_r + 1'b1);
    end
    else
      st_nxt.div_r = SCW'(st_r.div_r + 1'b1);

    pos = st_nxt.scan_r;
    case (mode)
      DISP_OCT_DATA:
        // (R9) eight octal data digits
        code = {1'b0, 3'(st_r.info_r >> (5'(pos) * 5'd3))};
      DISP_OCT_ADDR:
      begin
        // (R10) third and fifth blank
        if (pos != 3'd3 && pos != 3'd5)
        begin
          oidx = (pos < 3'd3) ? pos : (pos == 3'd4) ? 3'd3 : 3'(pos - 3'd2);
          code = {1'b0, 3'(addr18 >> (5'(oidx) * 5'd3))};
        end
      end
      DISP_MUX, DISP_MUX1:
      begin
        // (R18) (R19) point, blanks, zero suppression, sign
        case (pos)
          3'd2: code = bcd[3:0];
          3'd3: code = bcd[7:4];
          3'd4: code = bcd[11:8];
          3'd5:
          begin
            code = bcd[15:12];
            dp = 1'b1;
          end
          3'd6: code = (bcd[19:16] == 4'h0) ? CODE_BLANK : bcd[19:16];
          3'd7: code = neg ? CODE_MINUS : CODE_BLANK;
          default: code = CODE_BLANK;
        endcase
      end
      default: code = CODE_BLANK;
    endcase
    // (R17) shared segment decode
    st_nxt.seg_r = seg7(code);
    st_nxt.dp_r = dp;
    // (R16) one-of-eight enable
    st_nxt.en_r = 8'h01 << pos;

    if (rst_i)
    begin
      st_nxt = '0;
      st_nxt.ctrl_r = CTRL_RST;
      st_nxt.en_r = 8'h01;
      st_nxt.dac_a_r = to_dac(12'h000);
      st_nxt.dac_b_r = to_dac(12'h000);
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o = st_r.rdat_r;
  assign wb_ack_o = st_r.ack_r;
  assign seg_o = st_r.seg_r;
  assign dp_o = st_r.dp_r;
  assign digit_en_o = st_r.en_r;
  // (R20) lamp array from storage
  assign lamp_o = st_r.info_r;
  assign dac_a_o = st_r.dac_a_r;
  assign dac_b_o = st_r.dac_b_r;
  assign parity_led_o = st_r.per_r[LCW];
  assign update_led_o = st_r.upd_r[LCW];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_parity_flag: assert property (load_done_i && msg_err |=> st_r.perr_r) // (R2)
    else $error("parity flag not set");
  chk_parity_led: assert property (load_done_i && msg_err |=> parity_led_o [*2]) // (R4)
    else $error("parity indicator not lit");
  chk_parity_store: assert property (load_done_i && msg_err && !st_r.ctrl_r[CTRL_TRAP_ADDR] // (R3)
    && st_r.ctrl_r[CTRL_REP] |=> lamp_o == $past(msg_data_i[INFO_W-1:0]))
    else $error("errored message not stored");
  chk_addr_store: assert property (load_done_i && st_r.ctrl_r[CTRL_TRAP_ADDR] && addr_hit // (R7)
    && st_r.ctrl_r[CTRL_REP] |=> st_r.addr_r == $past(msg_addr))
    else $error("matching message not stored");
  chk_addr_miss: assert property (st_r.ctrl_r[CTRL_TRAP_ADDR] && !addr_hit |=> $stable(st_r.info_r)) // (R5)
    else $error("mismatched message stored");
  chk_storage_hold: assert property (!load_done_i |=> $stable(st_r.info_r) && $stable(dac_a_o)) // (R26)
    else $error("storage changed without strobe");
  chk_update_led: assert property (store |=> update_led_o [*3]) // (R8)
    else $error("update indicator not stretched");
  chk_single_arm: assert property (store && !st_r.ctrl_r[CTRL_REP] && !btn_edge |=> !st_r.armed_r) // (R27)
    else $error("arm not cleared after store");
  chk_digit_onehot: assert property ($onehot(digit_en_o)) // (R16)
    else $error("digit enable not one-hot");
  chk_dac_msb: assert property (store |=> dac_a_o[DAC_W-1] == !lamp_o[INFO_W-1]) // (R22)
    else $error("converter word not offset binary");
  chk_scan_rate: assert property (st_r.div_r != SCW'(SCAN_DIV - 1) |=> $stable(st_r.scan_r)) // (R15)
    else $error("scan advanced off tick");
  chk_dac_upper: assert property (store |=> dac_b_o == // (R23)
    {~$past(msg_data_i[HALF_W-1]), $past(msg_data_i[HALF_W-2:HALF_W-DAC_W])})
    else $error("converter word not upper bits");
  cov_parity_trap: cover property (load_done_i && msg_err && store);
  cov_addr_trap: cover property (load_done_i && st_r.ctrl_r[CTRL_TRAP_ADDR] && store);
  cov_single_press: cover property (btn_edge ##[1:200] store);
  cov_neg_analog: cover property (mode == DISP_MUX && neg && st_r.scan_r == 3'd7);
endmodule

//--- test/mtd_msg_src.sv
// Loader model: shifts a message bit by bit, then strobes load done
// Assumes the bench calls send just after a rising clock edge
`timescale 1ns/10ps
module mtd_msg_src
  import mtd_pkg::*;
(
  input wire logic clk_i,
  output logic msg_bit_o,
  output logic msg_shift_o,
  output logic load_done_o,
  output logic [MSG_W-1:0] msg_data_o
);
  initial
  begin
    msg_bit_o = 1'b0;
    msg_shift_o = 1'b0;
    load_done_o = 1'b0;
    msg_data_o = '0;
  end

  task automatic send(input logic [MSG_W-1:0] m, input int gap);
    for (int i = MSG_W - 1; i >= 0; i--)
    begin
      msg_shift_o <= 1'b1;
      msg_bit_o <= m[i];
      @(posedge clk_i);
      msg_shift_o <= 1'b0;
      msg_bit_o <= ~m[i];
      repeat (gap) @(posedge clk_i);
    end
    load_done_o <= 1'b1;
    msg_data_o <= m;
    @(posedge clk_i);
    load_done_o <= 1'b0;
    msg_data_o <= ~m;
  endtask
endmodule

//--- test/message_trap_display_tb.sv
// Bench: loader model, Wishbone tasks, store scoreboard, display probes
// Assumes mtd_top with short scan and indicator counts
`timescale 1ns/10ps
module message_trap_display_tb
  import mtd_pkg::*;
();
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic msg_bit, msg_shift, load_done, btn, cyc, stb, we, ack, dp, pled, uled, armed;
  logic uled_d = 1'b0;
  logic [MSG_W-1:0] msg_data;
  logic [7:0] adr, en;
  logic [3:0] sel;
  logic [31:0] wdat, rd_o, rd;
  logic [6:0] seg, ctrl;
  logic [INFO_W-1:0] lamp, last_info;
  logic [11:0] dac_a, dac_b;
  logic [ADDR_W-1:0] match, last_addr;
  logic [INFO_W:0] note;
  logic [INFO_W:0] exp_q[$];
  logic [63:0] r;
  logic [19:0] dtab[9] = '{20'h00006, 20'h13000, 20'h3206d, 20'h3513f, 20'h36000, 20'h27040, 20'h26006,
                           20'h20000, 20'h2513f};
  logic [15:0] flip[3] = '{16'h0400, 16'h0040, 16'h0001};
  integer seed = 32'h49cb43b1;
  int num_errors = 0;
  int checks = 0;

  always #4 clk_i = ~clk_i;

  mtd_msg_src src (.clk_i(clk_i), .msg_bit_o(msg_bit), .msg_shift_o(msg_shift), .load_done_o(load_done),
                   .msg_data_o(msg_data));
  mtd_top #(.SCAN_DIV(4), .LED_CYCLES(5), .DAC_W(12)) dut (.clk_i(clk_i), .rst_i(rst_i), .msg_bit_i(msg_bit),
    .msg_shift_i(msg_shift), .load_done_i(load_done), .msg_data_i(msg_data), .single_btn_i(btn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rd_o), .wb_ack_o(ack), .seg_o(seg), .dp_o(dp), .digit_en_o(en), .lamp_o(lamp),
    .dac_a_o(dac_a), .dac_b_o(dac_b), .parity_led_o(pled), .update_led_o(uled));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict;
    $display("Counts: %0d checks, %0d mismatches", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic hang;
    num_errors++;
    give_verdict();
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'hf;
    we <= w;
    adr <= a;
    wdat <= d;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_i);
      if (ack === 1'b1)
        break;
    end
    if (n == 50)
      hang();
    rd = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic msg(input logic [15:0] a, input logic [23:0] i, input logic pe, input int gap);
    logic hit;
    i[0] = i[0] ^ (^{a, i}) ^ pe;
    hit = (ctrl[2] || a[15:10] == match[15:10]) && (ctrl[3] || a[9:6] == match[9:6]) &&
          (ctrl[4] || a[5:0] == match[5:0]);
    if ((ctrl[0] ? hit : pe) && (ctrl[1] || armed))
    begin
      exp_q.push_back({pe, i});
      last_info = i;
      last_addr = a;
      armed = 1'b0;
    end
    src.send({a, i}, gap);
    repeat (10) @(posedge clk_i);
  endtask

  task automatic disp_chk(input logic [3:0] pos, input logic [6:0] s, input logic d);
    int n;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk_i);
      if (en === 8'h01 << pos)
        break;
    end
    if (n == 100)
      hang();
    cmp("seg", {25'h0, s}, {25'h0, seg});
    cmp("dp", {31'h0, d}, {31'h0, dp});
  endtask

  // ****************************************
  // Store monitor
  // ****************************************
  always @(posedge clk_i)
  begin
    uled_d <= uled;
    if (uled === 1'b1 && uled_d !== 1'b1)
    begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : 25'h1ffffff;
      cmp("lamp", {8'h0, note[23:0]}, {8'h0, lamp});
      cmp("dac_a", {20'h0, ~note[23], note[22:12]}, {20'h0, dac_a});
      cmp("dac_b", {20'h0, ~note[11], note[10:0]}, {20'h0, dac_b});
      cmp("parity_led", {31'h0, note[24]}, {31'h0, pled});
    end
  end

  initial
  begin
    btn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    ctrl = CTRL_RST;
    match = 16'h0;
    armed = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    cmp("dac_rst", 32'h800, {20'h0, dac_a});
    wb(1'b0, REG_CTRL, 32'h0);
    cmp("ctrl_rst", 32'h2, rd);
    $display("Test reset done");
    for (int k = 0; k < 4; k++)
    begin
      r = {$random(seed), $random(seed)};
      msg(r[63:48], r[23:0], k[0], k + 1);
    end
    $display("Test parity trap done");
    match = r[47:32];
    wb(1'b1, REG_MATCH, {16'h0, match});
    ctrl = 7'h03;
    wb(1'b1, REG_CTRL, 32'h3);
    msg(match, r[31:8], 1'b0, 1);
    msg(match ^ 16'h0400, r[23:0], 1'b1, 2);
    wb(1'b0, REG_STAT, 32'h0);
    cmp("status", {last_addr, 16'h1}, rd);
    wb(1'b1, REG_STAT, 32'h1);
    wb(1'b0, REG_STAT, 32'h0);
    cmp("status_clr", {last_addr, 16'h0}, rd);
    wb(1'b0, REG_INFO, 32'h0);
    cmp("info", {8'h0, last_info}, rd);
    wb(1'b0, 8'h10, 32'h0);
    cmp("unmapped", 32'h0, rd);
    for (int j = 0; j < 3; j++)
    begin
      ctrl = 7'h03;
      wb(1'b1, REG_CTRL, 32'h3);
      msg(match ^ flip[j], r[23:0] + j, 1'b0, 1);
      ctrl = 7'h03 | (7'h04 << j);
      wb(1'b1, REG_CTRL, {25'h0, ctrl});
      msg(match ^ flip[j], r[23:0] + j, 1'b0, 1);
    end
    $display("Test address trap done");
    ctrl = 7'h01;
    wb(1'b1, REG_CTRL, 32'h1);
    msg(match, r[55:32], 1'b0, 1);
    btn <= 1'b1;
    repeat (4) @(posedge clk_i);
    btn <= 1'b0;
    repeat (4) @(posedge clk_i);
    armed = 1'b1;
    wb(1'b0, REG_STAT, 32'h0);
    cmp("armed", 32'h2, {30'h0, rd[1], 1'b0});
    msg(match, r[55:32], 1'b1, 1);
    msg(match, r[39:16], 1'b0, 1);
    $display("Test single mode done");
    ctrl = 7'h03;
    wb(1'b1, REG_CTRL, 32'h3);
    msg(match, 24'h800001, ^{match, 24'h800001}, 1);
    for (int k = 0; k < 9; k++)
    begin
      ctrl = {dtab[k][17:16], 5'h03};
      wb(1'b1, REG_CTRL, {25'h0, ctrl});
      disp_chk(dtab[k][15:12], dtab[k][6:0], dtab[k][8]);
    end
    $display("Test display done");
    cmp("pending_stores", 32'h0, exp_q.size());
    give_verdict();
  end
endmodule
